// ===== hdl/fault_diagnostic_checks.sv
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module fault_diagnostic_checks (
	input  wire logic        mclk,              // 25 MHz clock
	input  wire logic        rst_n,             // Async reset, active low
	input  wire logic        ce,                // Clock enable, freezes all state
	input  wire logic [7:0]  address,           // Avalon byte address
	input  wire logic        read,              // Avalon read
	input  wire logic        write,             // Avalon write
	input  wire logic [31:0] writedata,         // Avalon write data
	input  wire logic [3:0]  byteenable,        // Avalon byte enables
	output logic      [31:0] readdata,          // Avalon read data
	output logic             waitrequest,       // Avalon wait request
	input  wire logic        temp_scan,         // Scan temperatures, one pulse
	input  wire logic [13:0] temp_code [4],     // Measured input codes, steady during scan
	input  wire logic        open_wire_valid,   // Scan wires result pulse
	input  wire logic [12:0] open_wire_hits,    // Open inputs found by the wire scan
	input  wire logic        nvm_load,          // Memory load started (power-up or reset cmd)
	input  wire logic [13:0] nvm_word,          // Loaded word, one per nvm_word_valid
	input  wire logic        nvm_word_valid,    // Loaded word strobe
	input  wire logic        nvm_load_done,     // Last word loaded
	input  wire logic [13:0] nvm_ref_sig,       // Reference signature held in memory
	output logic      [13:0] fs_report_data,    // Unsolicited fault status word
	output logic             fs_report_valid,   // Pulse with fs_report_data
	output logic             irq                // Level interrupt
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Every flop of the block except the configuration memory in one record, registered as a whole
	typedef struct packed {
		logic [31:0]                 readdata;
		logic                        waitrequest;
		logic [2:0]                  fault_status;
		logic [12:0]                 open_wire;
		logic [3:0]                  over_temp;
		logic [3:0]                  test_sel;
		logic [13:0]                 temp_limit;
		logic [13:0]                 csum_stored;
		logic [13:0]                 csum_acc;
		logic [4:0]                  csum_idx;
		logic                        csum_first;
		logic [13:0]                 sig_calc;
		logic [13:0]                 sig_ref;
		logic                        sig_busy;
		fault_diag_pkg::seq_state_t  state;
		logic [13:0]                 fs_report_data;
		logic                        fs_report_valid;
		logic [3:0]                  irq_status;
		logic [3:0]                  irq_enable;
		logic                        irq;
	} regs_t;

	regs_t       r;
	regs_t       next_r;
	// Memory port wiring; mem_rdata from the memory, the rest driven from the next-state logic
	logic [13:0] mem_rdata;
	logic        mem_we;
	logic [3:0]  mem_waddr;
	logic [13:0] mem_wdata;
	logic [3:0]  mem_raddr;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Signature step: shift with feedback, folding in the new word
	// Taps are arbitrary; the host only tests two signatures for equality
	function automatic logic [13:0] sig_step(input logic [13:0] s, input logic [13:0] w);
		logic fb;
		fb = s[13] ^ s[12] ^ s[10] ^ s[0];
		sig_step = {s[12:0], fb} ^ w;
	endfunction

	// Apply byte enables to a 32-bit register image
	// Byte lanes with a low enable keep the old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		merge = m;
	endfunction

	// Fourteen-bit modulo sum; the carry out is dropped on purpose
	function automatic logic [13:0] csum_add(input logic [13:0] acc, input logic [13:0] w);
		csum_add = acc + w;
	endfunction

	// ------------------------------------------------------------
	// Configuration page memory
	// ------------------------------------------------------------
	// The registered read adds the one-cycle lag that the walk allows for
	cfg_mem u_cfg_mem (
		.mclk  (mclk),
		.ce    (ce),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic        req;
		logic        is_wr;
		logic [31:0] m;
		logic [2:0]  fs_set;
		logic [12:0] ow_set;
		logic [3:0]  ot_set;
		logic [3:0]  ev;
		logic [2:0]  fs_clr;
		logic [12:0] ow_clr;
		logic [3:0]  ot_clr;
		logic [2:0]  fs_new;
		next_r = r;
		fs_new = 3'b000;
		req    = (read | write) & r.waitrequest;
		// A write lands only at the edge that ends the wait
		is_wr  = write & ~r.waitrequest;
		m      = merge(32'h00000000, writedata, byteenable);
		// Set and clear masks of the sticky flags
		fs_set = 3'b000;
		ow_set = 13'h0000;
		ot_set = 4'h0;
		ev     = 4'h0;
		fs_clr = 3'b000;
		ow_clr = 13'h0000;
		ot_clr = 4'h0;
		// Write port follows the bus, read port the walk index
		mem_we    = 1'b0;
		mem_waddr = address[5:2];
		mem_wdata = m[13:0];
		mem_raddr = r.csum_idx[3:0];
		// Strobes default low
		next_r.fs_report_valid = 1'b0;

		// Bus slave: one wait cycle, answer on the next edge
		// Read data are loaded when the request is seen and stand while waitrequest is low
		// Map: 00 summary, 04 open-wire, 08 over-temperature, all write one to clear
		//      0c test select, 10 limit, 14 command with busy in bit 2
		//      18 stored checksum, 1c computed and 20 reference signature
		//      24 irq status, 28 irq clear, 2c irq enable
		//      40 to 7c configuration words, write only
		// Anything else reads zero and ignores writes
		next_r.waitrequest = 1'b1;
		if (req) begin
			next_r.waitrequest = 1'b0;
			next_r.readdata    = fault_diag_pkg::UNMAPPED_DATA;
		end
		if (read && req) begin
			unique case (address)
				fault_diag_pkg::ADDR_FAULT_STATUS: next_r.readdata = {29'h0, r.fault_status};
				fault_diag_pkg::ADDR_OPEN_WIRE:    next_r.readdata = {19'h0, r.open_wire};
				fault_diag_pkg::ADDR_OVER_TEMP:    next_r.readdata = {28'h0, r.over_temp};
				fault_diag_pkg::ADDR_FAULT_SETUP:  next_r.readdata = {28'h0, r.test_sel};
				fault_diag_pkg::ADDR_TEMP_LIMIT:   next_r.readdata = {18'h0, r.temp_limit};
				fault_diag_pkg::ADDR_COMMAND:      next_r.readdata = {29'h0, r.state != fault_diag_pkg::ST_IDLE, 2'b00};
				fault_diag_pkg::ADDR_CSUM_STORED:  next_r.readdata = {18'h0, r.csum_stored};
				fault_diag_pkg::ADDR_SIG_CALC:     next_r.readdata = {18'h0, r.sig_calc};
				fault_diag_pkg::ADDR_SIG_REF:      next_r.readdata = {18'h0, r.sig_ref};
				fault_diag_pkg::ADDR_IRQ_STATUS:   next_r.readdata = {28'h0, r.irq_status};
				fault_diag_pkg::ADDR_IRQ_ENABLE:   next_r.readdata = {28'h0, r.irq_enable};
				default:                           next_r.readdata = fault_diag_pkg::UNMAPPED_DATA;
			endcase
		end

		// Writes; a one clears a fault flag, a zero leaves it
		if (is_wr) begin
			// Configuration words land in the memory, not in the record
			if (address >= fault_diag_pkg::ADDR_CFG_BASE && address[7:6] == 2'b01) begin
				mem_we = 1'b1;
			end
			unique case (address)
				fault_diag_pkg::ADDR_FAULT_STATUS: fs_clr = m[2:0];
				fault_diag_pkg::ADDR_OPEN_WIRE:    ow_clr = m[12:0];
				fault_diag_pkg::ADDR_OVER_TEMP:    ot_clr = m[3:0];
				fault_diag_pkg::ADDR_FAULT_SETUP:  next_r.test_sel = m[3:0];
				fault_diag_pkg::ADDR_TEMP_LIMIT:   next_r.temp_limit = m[13:0];
				fault_diag_pkg::ADDR_IRQ_CLEAR:    next_r.irq_status = r.irq_status & ~m[3:0];
				fault_diag_pkg::ADDR_IRQ_ENABLE:   next_r.irq_enable = m[3:0];
				fault_diag_pkg::ADDR_COMMAND: begin
					// Commands are ignored while a sequence runs
					// Calculate wins when both command bits are written
					if (r.state == fault_diag_pkg::ST_IDLE) begin
						if (m[fault_diag_pkg::CMD_CALC_BIT]) begin
							next_r.state = fault_diag_pkg::ST_CALC;
						end else if (m[fault_diag_pkg::CMD_CHECK_BIT]) begin
							next_r.state = fault_diag_pkg::ST_CHECK;
						end
						next_r.csum_idx   = 5'h00;
						next_r.csum_acc   = 14'h0000;
						next_r.csum_first = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Checksum walk; memory read data trails the index by one cycle
		// Index 0 only primes the read, so the last word is folded in at index 16
		// A config write during a walk is not held off: the host waits for busy to fall
		unique case (r.state)
			fault_diag_pkg::ST_IDLE: begin
			end
			fault_diag_pkg::ST_CALC, fault_diag_pkg::ST_CHECK: begin
				if (!r.csum_first) begin
					next_r.csum_acc = csum_add(r.csum_acc, mem_rdata);
				end
				next_r.csum_first = 1'b0;
				next_r.csum_idx   = r.csum_idx + 5'h01;
				if (r.csum_idx == 5'(fault_diag_pkg::CFG_WORDS)) begin
					next_r.csum_idx = r.csum_idx;
					if (r.state == fault_diag_pkg::ST_CALC) begin
						next_r.csum_stored = csum_add(r.csum_acc, mem_rdata);
					end else if (csum_add(r.csum_acc, mem_rdata) != r.csum_stored) begin
						fs_set[fault_diag_pkg::FS_CSUM_BIT] = 1'b1;
					end
					ev[fault_diag_pkg::EV_CSUM_DONE] = 1'b1;
					next_r.state = fault_diag_pkg::ST_FINISH;
				end
			end
			// One spare cycle so busy falls after the result is in place
			fault_diag_pkg::ST_SIG, fault_diag_pkg::ST_FINISH: begin
				next_r.state = fault_diag_pkg::ST_IDLE;
			end
			default: next_r.state = fault_diag_pkg::ST_IDLE;
		endcase

		// Temperature scan: immediate compare, no filtering
		// Inputs with a zero test select never raise a flag, whatever their code
		// Strict compare: a code equal to the limit passes
		if (temp_scan) begin
			for (int i = 0; i < fault_diag_pkg::NUM_TEMP; i++) begin
				if (r.test_sel[i] && temp_code[i] < r.temp_limit) begin
					ot_set[i] = 1'b1;
				end
			end
		end
		// A wire scan sets flags and never clears them
		if (open_wire_valid) begin
			ow_set = open_wire_hits;
		end
		if (|ot_set) begin
			fs_set[fault_diag_pkg::FS_OVER_TEMP_BIT] = 1'b1;
		end
		if (|ow_set) begin
			fs_set[fault_diag_pkg::FS_OPEN_WIRE_BIT] = 1'b1;
		end

		// Sticky flags: a set in the same cycle as a clear wins
		// Summary bits follow this cycle's sets, not the detail registers
		next_r.open_wire    = (r.open_wire & ~ow_clr) | ow_set;
		next_r.over_temp    = (r.over_temp & ~ot_clr) | ot_set;
		fs_new              = (r.fault_status & ~fs_clr) | fs_set;
		next_r.fault_status = fs_new;

		// Unsolicited report only when status was clear before the fault
		// Later faults show only in the summary until it is cleared again
		if (|fs_set && r.fault_status == 3'b000) begin
			next_r.fs_report_valid = 1'b1;
			next_r.fs_report_data  = {11'h000, fs_new};
			ev[fault_diag_pkg::EV_REPORT] = 1'b1;
		end
		if (|fs_set) begin
			ev[fault_diag_pkg::EV_FAULT] = 1'b1;
		end

		// Memory load signature
		// A new load reseeds and drops a half-built signature
		if (nvm_load) begin
			next_r.sig_busy = 1'b1;
			next_r.sig_calc = fault_diag_pkg::SIG_SEED;
		end else if (r.sig_busy) begin
			if (nvm_word_valid) begin
				next_r.sig_calc = sig_step(r.sig_calc, nvm_word);
			end
			if (nvm_load_done) begin
				next_r.sig_busy = 1'b0;
				next_r.sig_ref  = nvm_ref_sig;
				ev[fault_diag_pkg::EV_SIG_DONE] = 1'b1;
			end
		end

		// Interrupt: events win over a simultaneous clear
		// Status and enable combine after the update, so irq follows in one cycle
		next_r.irq_status = next_r.irq_status | ev;
		next_r.irq        = |(next_r.irq_status & next_r.irq_enable);
	end

	// ------------------------------------------------------------
	// Register stage
	// ------------------------------------------------------------
	// ce low holds every flag, counter and strobe as it is
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Bus idles with waitrequest high; limit starts at full scale
			r             <= '0;
			r.waitrequest <= 1'b1;
			r.temp_limit  <= fault_diag_pkg::TEMP_LIMIT_RESET;
			r.test_sel    <= fault_diag_pkg::SETUP_RESET;
			r.sig_calc    <= fault_diag_pkg::SIG_SEED;
			r.state       <= fault_diag_pkg::ST_IDLE;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	// Straight from the record, no logic between flop and pin
	assign readdata        = r.readdata;
	assign waitrequest     = r.waitrequest;
	assign fs_report_data  = r.fs_report_data;
	assign fs_report_valid = r.fs_report_valid;
	assign irq             = r.irq;

endmodule

// ===== hdl/fault_diag_pkg.sv
package fault_diag_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_OPEN_WIRE     = 8'h04;
	localparam logic [7:0] ADDR_OVER_TEMP     = 8'h08;
	localparam logic [7:0] ADDR_FAULT_SETUP   = 8'h0c;
	localparam logic [7:0] ADDR_TEMP_LIMIT    = 8'h10;
	localparam logic [7:0] ADDR_COMMAND       = 8'h14;
	localparam logic [7:0] ADDR_CSUM_STORED   = 8'h18;
	localparam logic [7:0] ADDR_SIG_CALC      = 8'h1c;
	localparam logic [7:0] ADDR_SIG_REF       = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h28;
	localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h2c;
	localparam logic [7:0] ADDR_CFG_BASE      = 8'h40;
	localparam logic [7:0] ADDR_FS_REPORT     = 8'h30;

	// ------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------
	localparam int         CODE_W             = 14;
	localparam int         NUM_TEMP           = 4;
	localparam int         NUM_WIRES          = 13;
	localparam int         CFG_WORDS          = 16;
	localparam int         CFG_AW             = 4;
	localparam int         FS_OPEN_WIRE_BIT   = 0;
	localparam int         FS_OVER_TEMP_BIT   = 1;
	localparam int         FS_CSUM_BIT        = 2;
	localparam int         SETUP_TST_LSB      = 0;
	localparam int         CMD_CALC_BIT       = 0;
	localparam int         CMD_CHECK_BIT      = 1;
	localparam int         CMD_RELOAD_BIT     = 2;

	// ------------------------------------------------------------
	// Reset values and constants
	// ------------------------------------------------------------
	localparam logic [13:0] TEMP_LIMIT_RESET  = 14'h3fff;
	localparam logic [13:0] FULL_SCALE_CODE   = 14'h3fff;
	localparam int          FULL_SCALE_MV     = 2500;
	localparam logic [3:0]  SETUP_RESET       = 4'h0;
	localparam logic [13:0] SIG_SEED          = 14'h0001;
	localparam logic [31:0] UNMAPPED_DATA     = 32'h00000000;

	// Interrupt event bits
	localparam int         EV_FAULT           = 0;
	localparam int         EV_REPORT          = 1;
	localparam int         EV_CSUM_DONE       = 2;
	localparam int         EV_SIG_DONE        = 3;
	localparam int         NUM_EV             = 4;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CALC   = 3'b001,
		ST_CHECK  = 3'b010,
		ST_SIG    = 3'b011,
		ST_FINISH = 3'b100
	} seq_state_t;

endpackage

// ===== hdl/cfg_mem.sv
`timescale 1ns/1ps
// Configuration page memory: one write port, registered read data
module cfg_mem (
	input  wire logic        mclk,    // System clock
	input  wire logic        ce,      // Clock enable
	input  wire logic        we,      // Write strobe
	input  wire logic [3:0]  waddr,   // Write index
	input  wire logic [13:0] wdata,   // Write word
	input  wire logic [3:0]  raddr,   // Read index
	output logic      [13:0] rdata    // Registered read word
);
	logic [13:0] mem [0:15];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// No reset: contents are software state, reloaded by the host
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule

// ===== testbench/fault_diag_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the diagnostic block
// ------------------------------------------------------------
module fault_diag_asserts (
	input wire logic        mclk,            // Clock
	input wire logic        rst_n,           // Async reset, active low
	input wire logic [7:0]  address,         // Bus address
	input wire logic        read,            // Bus read
	input wire logic        write,           // Bus write
	input wire logic [31:0] readdata,        // Bus read data
	input wire logic        waitrequest,     // Bus wait
	input wire logic        temp_scan,       // Scan pulse
	input wire logic [13:0] fs_report_data,  // Report word
	input wire logic        fs_report_valid, // Report strobe
	input wire logic        irq              // Interrupt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire req = read | write;

	// Bus answers one cycle after a fresh request, for one cycle only
	AST_WAIT_ONE: assert property (req && waitrequest && !$past(req) |=> !waitrequest)
		else $error("answer not one cycle after request");
	AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	AST_IDLE_WAIT: assert property (!req && !$past(req) |-> waitrequest)
		else $error("answer without request");
	AST_READ_HOLD: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
		else $error("read data moved between answers");
	AST_UNMAPPED_ZERO: assert property (read && waitrequest && address == 8'h38 |=> readdata == 32'h0)
		else $error("unmapped read not zero");
	// Unsolicited report is a lone pulse with a real fault in it
	AST_REPORT_PULSE: assert property (fs_report_valid |=> !fs_report_valid)
		else $error("report strobe too long");
	AST_REPORT_NONZERO: assert property (fs_report_valid |-> fs_report_data != 14'h0)
		else $error("report of empty status");
	AST_REPORT_TEMP: assert property (fs_report_valid && fs_report_data == 14'h0002 |->
		$past(temp_scan) || $past(temp_scan, 2) || $past(temp_scan, 3))
		else $error("over-temperature report without scan");

	COV_REPORT: cover property (fs_report_valid);
	COV_UNMAPPED: cover property (read && address == 8'h38 && !waitrequest);
	COV_IRQ: cover property ($rose(irq));
endmodule

// ===== testbench/host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host bus master with the host's fault handling routines
// ------------------------------------------------------------
module host_model (
	input  wire logic        mclk,        // Clock
	input  wire logic        waitrequest, // Slave wait
	input  wire logic [31:0] readdata,    // Slave read data
	output logic      [7:0]  address,     // Bus address
	output logic             read,        // Bus read
	output logic             write,       // Bus write
	output logic      [31:0] writedata,   // Bus write data
	output logic      [3:0]  byteenable   // Byte enables
);
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
	end

	// Request held until the rising edge that sees waitrequest low; one idle edge after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge mclk);
	endtask

	// Read data are taken at the same edge that ends the wait
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		address <= a;
		read <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		@(posedge mclk);
	endtask

	// Detail register is only worth reading when the summary shows a fault
	task automatic fault_read(input logic [7:0] det_addr, output logic [31:0] st, output logic [31:0] det);
		rd(fault_diag_pkg::ADDR_FAULT_STATUS, st);
		det = 32'h0;
		if (st !== 32'h0) rd(det_addr, det);
	endtask

	// Detail flags go first; either order works, as set detail flags never raise the summary again
	task automatic clear_faults(input logic [7:0] det_addr, input logic [31:0] det_bits, input logic [31:0] sum_bits);
		wr(det_addr, det_bits);
		wr(fault_diag_pkg::ADDR_FAULT_STATUS, sum_bits);
	endtask

	// Checksum command, then poll the busy bit; a hang is cut by the bench timeout
	task automatic command(input logic [31:0] c);
		logic [31:0] s;
		wr(fault_diag_pkg::ADDR_COMMAND, c);
		s = 32'h4;
		while (s[2] !== 1'b0) rd(fault_diag_pkg::ADDR_COMMAND, s);
	endtask
endmodule

// ===== testbench/fault_diagnostic_checks_test.sv
`timescale 1ns/1ps
module fault_diagnostic_checks_test;
	logic        mclk, rst_n, ce, read, write, waitrequest, irq, temp_scan;
	logic        open_wire_valid, nvm_load, nvm_word_valid, nvm_load_done, fs_report_valid;
	logic [7:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata, d, s1;
	logic [31:0] rep_cnt = 32'h0, cycles = 32'h0;
	logic [13:0] temp_code [4];
	logic [13:0] nvm_word, nvm_ref_sig, fs_report_data, sum;
	logic [13:0] rep_data = 14'h0;
	logic [12:0] open_wire_hits;
	int          miscompares, checked;

	fault_diagnostic_checks dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .temp_scan(temp_scan), .temp_code(temp_code),
		.open_wire_valid(open_wire_valid), .open_wire_hits(open_wire_hits), .nvm_load(nvm_load),
		.nvm_word(nvm_word), .nvm_word_valid(nvm_word_valid), .nvm_load_done(nvm_load_done),
		.nvm_ref_sig(nvm_ref_sig), .fs_report_data(fs_report_data), .fs_report_valid(fs_report_valid), .irq(irq));
	host_model host_u (.mclk(mclk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Report capture and run ceiling; a normal run needs about 300 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 32'd1;
		if (fs_report_valid === 1'b1) begin
			rep_cnt <= rep_cnt + 32'd1;
			rep_data <= fs_report_data;
		end
		if (cycles == 32'd8000) begin
			miscompares++;
			wrap_up;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		host_u.rd(a, d);
		chk(what, d, exp);
	endtask

	// One scan pulse, then four clock edges for the flags to settle
	task automatic scan;
		temp_scan <= 1'b1;
		@(posedge mclk);
		temp_scan <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	// One memory load: n fixed words then the reference signature
	task automatic nvm_run(input int n, input logic [13:0] ref_sig);
		nvm_load <= 1'b1;
		@(posedge mclk);
		nvm_load <= 1'b0;
		for (int k = 0; k < n; k++) begin
			nvm_word <= 14'h0a5 + 14'(k);
			nvm_word_valid <= 1'b1;
			@(posedge mclk);
		end
		nvm_word_valid <= 1'b0;
		nvm_ref_sig <= ref_sig;
		nvm_load_done <= 1'b1;
		@(posedge mclk);
		nvm_load_done <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic wrap_up;
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		temp_scan = 1'b0;
		temp_code = '{default: 14'h0};
		open_wire_valid = 1'b0;
		open_wire_hits = 13'h0;
		{nvm_load, nvm_word_valid, nvm_load_done, nvm_word, nvm_ref_sig} = '0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rdchk(fault_diag_pkg::ADDR_TEMP_LIMIT, 32'h3fff, "limit reset");
		rdchk(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h0, "setup reset");
		rdchk(8'h38, 32'h0, "unmapped read");
		// Open wire with the interrupt masked, then enabled
		open_wire_hits <= 13'h1001;
		open_wire_valid <= 1'b1;
		@(posedge mclk);
		open_wire_valid <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("report count", rep_cnt, 32'd1);
		chk("report data", {18'h0, rep_data}, 32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		host_u.wr(fault_diag_pkg::ADDR_IRQ_ENABLE, 32'hf);
		chk("irq enabled", {31'h0, irq}, 32'h1);
		rdchk(fault_diag_pkg::ADDR_IRQ_STATUS, 32'h3, "irq status");
		host_u.fault_read(fault_diag_pkg::ADDR_OPEN_WIRE, d, s1);
		chk("status open", d, 32'h1);
		chk("open detail", s1, 32'h1001);
		host_u.clear_faults(fault_diag_pkg::ADDR_OPEN_WIRE, 32'h1fff, 32'h1);
		rdchk(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "status cleared");
		host_u.wr(fault_diag_pkg::ADDR_IRQ_CLEAR, 32'hf);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		// Over-temperature: below, unselected, equal, above
		host_u.wr(fault_diag_pkg::ADDR_TEMP_LIMIT, 32'h2000);
		host_u.wr(fault_diag_pkg::ADDR_FAULT_SETUP, 32'h5);
		temp_code <= '{14'h1fff, 14'h0000, 14'h2000, 14'h3fff};
		scan();
		host_u.fault_read(fault_diag_pkg::ADDR_OVER_TEMP, d, s1);
		chk("status temp", d, 32'h2);
		chk("temp detail", s1, 32'h1);
		chk("report data temp", {18'h0, rep_data}, 32'h2);
		host_u.wr(fault_diag_pkg::ADDR_FAULT_SETUP, 32'hf);
		scan();
		rdchk(fault_diag_pkg::ADDR_OVER_TEMP, 32'h3, "temp all selected");
		chk("no second report", rep_cnt, 32'd2);
		host_u.clear_faults(fault_diag_pkg::ADDR_OVER_TEMP, 32'hf, 32'h2);
		rdchk(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "temp cleared");
		// Configuration checksum: store, pass, corrupt, repair
		sum = 14'h0;
		for (int i = 0; i < 16; i++) begin
			host_u.wr(fault_diag_pkg::ADDR_CFG_BASE + 8'(4 * i), 32'h2a7 + 32'(i * 32'h3c1));
			sum = sum + 14'(32'h2a7 + 32'(i * 32'h3c1));
		end
		host_u.command(32'h1);
		rdchk(fault_diag_pkg::ADDR_CSUM_STORED, {18'h0, sum}, "stored checksum");
		host_u.command(32'h2);
		rdchk(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "checksum pass");
		host_u.wr(fault_diag_pkg::ADDR_CFG_BASE + 8'h14, 32'h2a6 + 32'h3c1 * 5);
		host_u.command(32'h2);
		rdchk(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h4, "checksum fault");
		chk("report data csum", {18'h0, rep_data}, 32'h4);
		host_u.wr(fault_diag_pkg::ADDR_CFG_BASE + 8'h14, 32'h2a7 + 32'h3c1 * 5);
		host_u.wr(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h4);
		host_u.command(32'h2);
		rdchk(fault_diag_pkg::ADDR_FAULT_STATUS, 32'h0, "repaired");
		rdchk(fault_diag_pkg::ADDR_IRQ_STATUS, 32'h7, "irq csum done");
		// Signature: an empty load leaves the seed, the same load twice gives the same value
		nvm_run(0, 14'h1234);
		rdchk(fault_diag_pkg::ADDR_SIG_CALC, {18'h0, fault_diag_pkg::SIG_SEED}, "empty load signature");
		nvm_run(4, 14'h1234);
		rdchk(fault_diag_pkg::ADDR_SIG_REF, 32'h1234, "ref signature");
		host_u.rd(fault_diag_pkg::ADDR_SIG_CALC, s1);
		chk("signature moved", {31'h0, s1 !== {18'h0, fault_diag_pkg::SIG_SEED}}, 32'h1);
		// Host compares; on a mismatch the memory is reloaded and checked again
		if (s1 !== 32'h1234) nvm_run(4, s1[13:0]);
		rdchk(fault_diag_pkg::ADDR_SIG_CALC, s1, "signature repeat");
		rdchk(fault_diag_pkg::ADDR_SIG_REF, s1, "signature match");
		rdchk(fault_diag_pkg::ADDR_IRQ_STATUS, 32'hf, "irq sig done");
		wrap_up();
	end
endmodule

bind fault_diagnostic_checks fault_diag_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .address(address),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .temp_scan(temp_scan),
	.fs_report_data(fs_report_data), .fs_report_valid(fs_report_valid), .irq(irq));
